// ### src/etc_event_capture.sv
// event timestamp capture: edge detect, event count, first sample time, cascade chain
// assumes ptp seconds/nanoseconds and a phase slot strobe arrive on the same clock
// What this block does
// [RULE1] 4-bit read-only count of detected edges
// [RULE2] detects edges up to 25 MHz
// [RULE3] overflow flag set, count held at 15
// [RULE4] in chain, only last unit flags overflow
// [RULE5] rising edges detected only when bit 7
// [RULE6] falling edges detected only when bit 6
// [RULE7] bit 5 marks last unit of chain
// [RULE8] bit 1 selects upstream done unit
// [RULE9] software sets upstream select 0 in head
// [RULE10] bit 0 includes unit in chain mode
// [RULE11] first sample polarity in ns bit 30
// [RULE12] first sample nanoseconds in bits 29:0
// [RULE13] first sample seconds, full 32 bits
// [RULE14] 3-bit 8 ns slot code of first sample
// [RULE15] unit index bit 8 selects exposed unit
// [RULE16] first enabled edge fills first-sample registers
`default_nettype none
module etc_event_capture #(
  parameter int UNITS = 2
) (
  input wire logic clock,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // event pins, one per unit, asynchronous
  input wire logic [UNITS-1:0] event_in,
  // ptp time on this clock
  input wire logic [31:0] ptp_sec,
  input wire logic [29:0] ptp_nanosec,
  // one-cycle pulse at the start of each 40 ns period
  input wire logic ptp_period_start,
  // done strobes toward a downstream chain partner
  output logic [UNITS-1:0] unit_done,
  output logic irq
);
  import etc_pkg::*;

  // elaboration check on the unit count
  // only two units can be addressed by the one index bit and upstream select
  // a wider index would need a wider pointer field and a wider upstream select
  generate
    if (UNITS != 2)
    begin : g_bad_units
      $error("etc_event_capture: UNITS must be 2");
    end
  endgenerate

  // overview of the datapath, for the next reader:
  // - each pin passes two flops before anything looks at it
  // - a third flop keeps the previous level, so one edge gives one hit
  // - a hit is an enabled transition that the chain logic lets through
  // - the counter saturates at its ceiling instead of wrapping
  // - only the hit that finds the counter empty latches the time
  // - later hits leave the first sample alone, so software can read it late
  // - the phase slot comes from a tick counter restarted by the period strobe
  // - the register view always shows the unit chosen by the index pointer
  // - every bus access is answered one cycle after it is taken
  // limitation: the pin pulse must last longer than two clock periods,
  // otherwise the synchroniser may swallow it; 25 MHz edges leave margin
  // trade-off: the extra synchroniser latency shifts every capture by the
  // same amount, so differences between samples stay exact

  // per unit state
  // control bits are kept as vectors so the index selects one bit of each
  // count and time are kept as small arrays, one word per unit
  logic [UNITS-1:0] rise_en_reg;
  logic [UNITS-1:0] fall_en_reg;
  logic [UNITS-1:0] last_unit_reg;
  logic [UNITS-1:0] upstream_sel_reg;
  logic [UNITS-1:0] chain_en_reg;
  logic [3:0] count_reg [UNITS];
  logic [UNITS-1:0] overflow_reg;
  logic [UNITS-1:0] polarity_reg;
  logic [29:0] nanosec_reg [UNITS];
  logic [31:0] sec_reg [UNITS];
  logic [2:0] slot_reg [UNITS];
  logic [UNITS-1:0] armed_reg; // chain unit has received its upstream done
  // pin synchronisers and edge history
  logic [UNITS-1:0] sync1_reg;
  logic [UNITS-1:0] sync2_reg;
  logic [UNITS-1:0] prev_reg;
  // global index and interrupts
  logic index_reg;
  logic [ETC_IRQ_WIDTH-1:0] irq_status_reg;
  logic [ETC_IRQ_WIDTH-1:0] irq_mask_reg;
  // slot counter inside the 40 ns period, in 4 ns cycles
  // it stops at its last value if the period strobe goes missing,
  // so a lost strobe gives the last slot rather than a reserved code
  logic [3:0] tick_reg;
  logic [2:0] slot_code;
  // bus decode
  logic bus_req;
  logic bus_wr;
  logic [31:0] rd_next;
  // per unit event strobes
  logic [UNITS-1:0] edge_hit;
  logic [UNITS-1:0] ovf_hit;

  // two-flop synchroniser, then one flop of history; 250 MHz gives margin for 25 MHz edges
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      sync1_reg <= event_in;
      sync2_reg <= sync1_reg; // [RULE2]
      prev_reg <= sync2_reg;
    end
  end

  // count 4 ns ticks within the period; restarts on the period strobe
  always_ff @(posedge clock)
  begin
    if (sys_rst || ptp_period_start)
      tick_reg <= '0;
    else if (tick_reg != 4'(ETC_PERIOD_NS * ETC_CLOCK_MHZ / 1000 - 1))
      tick_reg <= tick_reg + 4'h1;
  end

  // map tick to the 8 ns slot code; two ticks per slot at 250 MHz
  always_comb
  begin
    unique case (tick_reg[3:1])
      3'h0: slot_code = ETC_SLOT_CODE0;
      3'h1: slot_code = ETC_SLOT_CODE1;
      3'h2: slot_code = ETC_SLOT_CODE2;
      3'h3: slot_code = ETC_SLOT_CODE3;
      default: slot_code = ETC_SLOT_CODE4; // [RULE14]
    endcase
  end

  // a request is taken only while no ack is out, so a held strobe
  // after the ack does not start a second access
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land on the same edge that raises the ack
  assign bus_wr = bus_req && wb_we_i;

  // per unit edge qualification, counting and first capture
  // one copy of the logic per unit; the units share only the done strobes
  // hazard: a unit chained to itself would arm on its own done pulse,
  // which is why the arming below refuses a select that points home
  generate
    for (genvar u = 0; u < UNITS; u++)
    begin : g_unit
      logic rise;
      logic fall;
      logic allowed;
      // an enabled transition of the synchronised pin
      assign rise = sync2_reg[u] && !prev_reg[u] && rise_en_reg[u]; // [RULE5]
      assign fall = !sync2_reg[u] && prev_reg[u] && fall_en_reg[u]; // [RULE6]
      // in a chain a unit waits for its upstream done; the head has none
      assign allowed = !chain_en_reg[u] || armed_reg[u]; // [RULE10]
      assign edge_hit[u] = (rise || fall) && allowed;
      // overflow: a hit with counter already full; chained non-last units stay silent
      assign ovf_hit[u] = edge_hit[u] && count_reg[u] == ETC_COUNT_MAX
                          && (!chain_en_reg[u] || last_unit_reg[u]); // [RULE4] [RULE7]

      // arming from the selected upstream unit's done strobe
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          armed_reg[u] <= 1'b0;
        else if (!chain_en_reg[u])
          armed_reg[u] <= 1'b0;
        else if (unit_done[upstream_sel_reg[u]] && upstream_sel_reg[u] != 1'(u)) // [RULE8] [RULE9]
          armed_reg[u] <= 1'b1;
        else if (u == 0 && !upstream_sel_reg[u])
          armed_reg[u] <= 1'b1; // head pointing at itself runs freely
      end

      // event counter and overflow; software clears both by writing one to the overflow bit
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          count_reg[u] <= '0;
          overflow_reg[u] <= 1'b0;
        end
        else if (edge_hit[u])
        begin
          if (count_reg[u] != ETC_COUNT_MAX)
            count_reg[u] <= count_reg[u] + 4'h1; // [RULE1]
          if (ovf_hit[u])
            overflow_reg[u] <= 1'b1; // [RULE3]
        end
        else if (bus_wr && index_reg == 1'(u) && wb_adr_i == ETC_STATUS_CONTROL_OFS && wb_sel_i[2]
                 && wb_dat_i[ETC_OVERFLOW_BIT])
        begin
          // writing one to bit 16 rearms the unit; an edge in that cycle wins
          count_reg[u] <= '0;
          overflow_reg[u] <= 1'b0;
        end
      end

      // first sample latch: only the edge that finds the counter at zero
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          polarity_reg[u] <= 1'b0;
          nanosec_reg[u] <= '0;
          sec_reg[u] <= '0;
          slot_reg[u] <= '0;
        end
        else if (edge_hit[u] && count_reg[u] == 4'h0) // [RULE16]
        begin
          polarity_reg[u] <= rise; // [RULE11]
          nanosec_reg[u] <= ptp_nanosec; // [RULE12]
          sec_reg[u] <= ptp_sec; // [RULE13]
          slot_reg[u] <= slot_code; // [RULE14]
        end
      end

      // done pulse once the unit has taken its first sample in chain mode
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          unit_done[u] <= 1'b0;
        else
          unit_done[u] <= chain_en_reg[u] && edge_hit[u] && count_reg[u] == 4'h0;
      end
    end
  endgenerate

  // control bits of the indexed unit
  // only the low byte lane carries control bits; other lanes leave them
  // reserved bits are not stored and read back as zero
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rise_en_reg <= '0;
      fall_en_reg <= '0;
      last_unit_reg <= '0;
      upstream_sel_reg <= '0;
      chain_en_reg <= '0;
    end
    else if (bus_wr && wb_adr_i == ETC_STATUS_CONTROL_OFS && wb_sel_i[0])
    begin
      rise_en_reg[index_reg] <= wb_dat_i[ETC_RISE_EN_BIT]; // [RULE5]
      fall_en_reg[index_reg] <= wb_dat_i[ETC_FALL_EN_BIT]; // [RULE6]
      last_unit_reg[index_reg] <= wb_dat_i[ETC_LAST_UNIT_BIT]; // [RULE7]
      upstream_sel_reg[index_reg] <= wb_dat_i[ETC_UPSTREAM_SEL_BIT]; // [RULE8]
      chain_en_reg[index_reg] <= wb_dat_i[ETC_CHAIN_EN_BIT]; // [RULE10]
    end
  end

  // unit index pointer
  // the pointer sits in the second byte lane, so it needs sel[1]
  // changing it does not disturb any unit, it only moves the view
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      index_reg <= 1'b0;
    else if (bus_wr && wb_adr_i == ETC_UNIT_INDEX_OFS && wb_sel_i[1])
      index_reg <= wb_dat_i[ETC_INDEX_BIT]; // [RULE15]
  end

  // sticky interrupt status, write one to clear, set wins over clear
  // set wins so an event in the clearing cycle is never lost
  // bit 0 gathers hits of all units, bit 1 overflows of all units
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      irq_status_reg <= '0;
    else
    begin
      for (int b = 0; b < ETC_IRQ_WIDTH; b++)
      begin
        if ((b == ETC_IRQ_EDGE_BIT && |edge_hit) || (b == ETC_IRQ_OVF_BIT && |ovf_hit))
          irq_status_reg[b] <= 1'b1;
        else if (bus_wr && wb_adr_i == ETC_IRQ_STATUS_OFS && wb_sel_i[0] && wb_dat_i[b])
          irq_status_reg[b] <= 1'b0;
      end
    end
  end

  // interrupt mask
  // same layout as the status; a one lets that status bit reach irq
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      irq_mask_reg <= '0;
    else if (bus_wr && wb_adr_i == ETC_IRQ_MASK_OFS && wb_sel_i[0])
      irq_mask_reg <= wb_dat_i[ETC_IRQ_WIDTH-1:0];
  end

  // registered level interrupt
  // one cycle behind the status, traded for a glitch-free pin
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(irq_status_reg & irq_mask_reg);
  end

  // read mux over the indexed unit; unmapped reads give zero
  // the address is compared whole, so aliases read as unmapped
  // reserved fields are left at the zero of the default assignment
  always_comb
  begin
    rd_next = '0;
    unique case (wb_adr_i)
      ETC_STATUS_CONTROL_OFS:
      begin
        rd_next[ETC_COUNT_MSB:ETC_COUNT_LSB] = count_reg[index_reg]; // [RULE1]
        rd_next[ETC_OVERFLOW_BIT] = overflow_reg[index_reg]; // [RULE3]
        rd_next[ETC_RISE_EN_BIT] = rise_en_reg[index_reg];
        rd_next[ETC_FALL_EN_BIT] = fall_en_reg[index_reg];
        rd_next[ETC_LAST_UNIT_BIT] = last_unit_reg[index_reg];
        rd_next[ETC_UPSTREAM_SEL_BIT] = upstream_sel_reg[index_reg];
        rd_next[ETC_CHAIN_EN_BIT] = chain_en_reg[index_reg];
      end
      ETC_FIRST_NS_OFS:
      begin
        rd_next[ETC_POLARITY_BIT] = polarity_reg[index_reg]; // [RULE11]
        rd_next[ETC_NS_MSB:0] = nanosec_reg[index_reg]; // [RULE12]
      end
      ETC_FIRST_SEC_OFS: rd_next = sec_reg[index_reg]; // [RULE13]
      ETC_FIRST_PHASE_OFS: rd_next[2:0] = slot_reg[index_reg]; // [RULE14]
      ETC_UNIT_INDEX_OFS: rd_next[ETC_INDEX_BIT] = index_reg; // [RULE15]
      ETC_IRQ_STATUS_OFS: rd_next[ETC_IRQ_WIDTH-1:0] = irq_status_reg;
      ETC_IRQ_MASK_OFS: rd_next[ETC_IRQ_WIDTH-1:0] = irq_mask_reg;
      default: rd_next = '0;
    endcase
  end

  // one-cycle ack, registered read data; every address is acknowledged
  // acking unmapped addresses keeps a stray access from hanging the bus
  // data is zero outside the ack cycle so a wired-or bus stays clean
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_next : 32'h0;
    end
  end
endmodule : etc_event_capture
`default_nettype wire

// ### src/etc_pkg.sv
// package for the event timestamp capture block: offsets, field positions, counter ceiling, timing, slot codes
// assumes a 32-bit classic wishbone register bus and a ptp time supplied on the same clock
`default_nettype none
package etc_pkg;
  // register byte offsets
  localparam logic [11:0] ETC_STATUS_CONTROL_OFS = 12'h550;
  localparam logic [11:0] ETC_FIRST_NS_OFS = 12'h554;
  localparam logic [11:0] ETC_FIRST_SEC_OFS = 12'h558;
  localparam logic [11:0] ETC_FIRST_PHASE_OFS = 12'h55c;
  localparam logic [11:0] ETC_UNIT_INDEX_OFS = 12'h560;
  localparam logic [11:0] ETC_IRQ_STATUS_OFS = 12'h570;
  localparam logic [11:0] ETC_IRQ_MASK_OFS = 12'h574;
  // register fields: status/control, first sample nanoseconds, unit index
  localparam int ETC_COUNT_LSB = 17;
  localparam int ETC_COUNT_MSB = 20;
  localparam int ETC_OVERFLOW_BIT = 16;
  localparam int ETC_RISE_EN_BIT = 7;
  localparam int ETC_FALL_EN_BIT = 6;
  localparam int ETC_LAST_UNIT_BIT = 5;
  localparam int ETC_UPSTREAM_SEL_BIT = 1;
  localparam int ETC_CHAIN_EN_BIT = 0;
  localparam int ETC_POLARITY_BIT = 30;
  localparam int ETC_NS_MSB = 29;
  localparam int ETC_INDEX_BIT = 8;
  // interrupt status bits
  localparam int ETC_IRQ_EDGE_BIT = 0;
  localparam int ETC_IRQ_OVF_BIT = 1;
  localparam int ETC_IRQ_WIDTH = 2;
  // counter ceiling
  localparam logic [3:0] ETC_COUNT_MAX = 4'hf;
  // phase slot: 8 ns slots inside a 40 ns period
  localparam int ETC_SLOT_NS = 8;
  localparam int ETC_PERIOD_NS = 40;
  localparam int ETC_CLOCK_MHZ = 250;
  localparam int ETC_SLOT_COUNT = ETC_PERIOD_NS / ETC_SLOT_NS;
  // slot codes; the 16 ns slot uses 010 since 101 is reserved
  localparam logic [2:0] ETC_SLOT_CODE0 = 3'h0;
  localparam logic [2:0] ETC_SLOT_CODE1 = 3'h1;
  localparam logic [2:0] ETC_SLOT_CODE2 = 3'h2;
  localparam logic [2:0] ETC_SLOT_CODE3 = 3'h3;
  localparam logic [2:0] ETC_SLOT_CODE4 = 3'h4;
endpackage : etc_pkg
`default_nettype wire

// ### testbench/etc_event_capture_checker.sv
// checker for the event capture block: bus handshake, read fields, done timing
// assumes it is bound to the top module ports
`default_nettype none
module etc_event_capture_checker #(
  parameter int UNITS = 2
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [UNITS-1:0] event_in,
  input wire logic [UNITS-1:0] unit_done,
  input wire logic irq
);
  import etc_pkg::*;
  logic [3:0] since_reg; // cycles since pin 0 moved
  logic ev_reg; // pin 0 one cycle ago
  logic rd; // read answer on the bus
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  assign rd = wb_ack_o && !wb_we_i;
  // saturating age of the last pin change; done may only follow a change
  always_ff @(posedge clock)
  begin
    ev_reg <= event_in[0];
    if (sys_rst)
      since_reg <= 4'hf;
    else if (ev_reg != event_in[0])
      since_reg <= 4'h0;
    else if (since_reg != 4'hf)
      since_reg <= since_reg + 4'h1;
  end
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data without ack");
  AST_STAT_RSV: assert property (rd && wb_adr_i == ETC_STATUS_CONTROL_OFS |->
    wb_dat_o[31:21] == 11'h0 && wb_dat_o[15:8] == 8'h0 && wb_dat_o[4:2] == 3'h0) else $error("reserved set");
  AST_OVF_HOLD: assert property (rd && wb_adr_i == ETC_STATUS_CONTROL_OFS && wb_dat_o[16] |->
    wb_dat_o[20:17] == 4'hf) else $error("overflow count");
  AST_NS_RSV: assert property (rd && wb_adr_i == ETC_FIRST_NS_OFS |-> !wb_dat_o[31])
    else $error("ns bit 31");
  AST_PHASE: assert property (rd && wb_adr_i == ETC_FIRST_PHASE_OFS |-> wb_dat_o < 32'h5)
    else $error("phase code");
  AST_DONE_LAG: assert property (unit_done[0] |-> since_reg >= 4'h2 && since_reg <= 4'h5)
    else $error("done timing");
  AST_DONE_ONE: assert property (unit_done[0] |=> !unit_done[0])
    else $error("done held");
  cover property (rd && wb_dat_o[16]);
  cover property ($rose(irq));
  cover property (unit_done[0]);
endmodule // etc_event_capture_checker
`default_nettype wire

// ### testbench/etc_event_src.sv
// pin model for the event inputs: one level change per call
// assumes a free-running bench clock; pins are always driven
`default_nettype none
module etc_event_src (
  input wire logic clock,
  output logic [1:0] event_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial event_in = 2'b00;
  // move one pin, then hold it longer than one 40 ns period
  task automatic flip(input int u);
    @(posedge clock);
    event_in[u] <= ~event_in[u];
    repeat (12) @(posedge clock);
  endtask
endmodule // etc_event_src
`default_nettype wire

// ### testbench/etc_event_capture_tb.sv
// bench for the event capture block: wishbone tasks, random ptp time, pin model
// assumes package, design, checker and pin model are compiled first
`default_nettype none
module etc_event_capture_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import etc_pkg::*;
  localparam logic [11:0] ST = ETC_STATUS_CONTROL_OFS;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, ptp_period_start = 1'b0;
  logic [11:0] wb_adr_i = 12'h0;
  logic [3:0] wb_sel_i = 4'h0, tick = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, ptp_sec = 32'h0, lfsr = 32'h50, wb_dat_o, rdata, s0;
  logic [29:0] ptp_nanosec = 30'h0, n0;
  logic [1:0] event_in, unit_done;
  logic wb_ack_o, irq;
  int mismatches = 0, cmp_count = 0;
  always #2 clock = ~clock;
  // phase reference pulse every tenth cycle
  always @(posedge clock)
  begin
    tick <= (tick == 4'h9) ? 4'h0 : tick + 4'h1;
    ptp_period_start <= (tick == 4'h9);
  end
  etc_event_capture #(.UNITS(2)) DUT (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_in(event_in),
    .ptp_sec(ptp_sec), .ptp_nanosec(ptp_nanosec), .ptp_period_start(ptp_period_start),
    .unit_done(unit_done), .irq(irq));
  etc_event_src src (.clock(clock), .event_in(event_in));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected status word; only control bits 7,6,5,1,0 are writable
  function automatic logic [31:0] stat(input logic [3:0] c, input logic o, input logic [7:0] k);
    return {11'h0, c, o, 8'h0, k & 8'he3};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled; bounded wait
  task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      finish_test();
    end
    rdata = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] e);
    bus(1'b0, a, 4'hf, 32'h0);
    chk(nm, rdata, e);
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      rd(ST + 12'(4 * i), "reset", 32'h0);
    rd(12'h7fc, "unmapped", 32'h0);
    bus(1'b1, ST, 4'h1, 32'hffffffff);
    rd(ST, "ctl", stat(4'h0, 1'b0, 8'hff));
    lfsr = nxt(lfsr);
    bus(1'b1, ST, 4'h1, {lfsr[31:17], 1'b0, lfsr[15:8], 8'h80});
    lfsr = nxt(lfsr);
    bus(1'b1, ETC_FIRST_SEC_OFS, 4'hf, lfsr);
    rd(ETC_FIRST_SEC_OFS, "sec read only", 32'h0);
    lfsr = nxt(lfsr);
    s0 = lfsr;
    lfsr = nxt(lfsr);
    n0 = {2'h0, lfsr[27:0]};
    ptp_sec <= s0;
    ptp_nanosec <= n0;
    src.flip(0);
    rd(ST, "rise", stat(4'h1, 1'b0, 8'h80));
    rd(ETC_FIRST_NS_OFS, "ns", {2'b01, n0});
    rd(ETC_FIRST_SEC_OFS, "sec", s0);
    bus(1'b0, ETC_FIRST_PHASE_OFS, 4'hf, 32'h0);
    chk("phase", 32'(rdata < 32'h5), 32'h1);
    src.flip(0);
    rd(ST, "fall off", stat(4'h1, 1'b0, 8'h80));
    bus(1'b1, ST, 4'h1, 32'hc0);
    lfsr = nxt(lfsr);
    ptp_sec <= lfsr;
    src.flip(0);
    rd(ETC_FIRST_SEC_OFS, "first kept", s0);
    rd(ST, "both", stat(4'h2, 1'b0, 8'hc0));
    repeat (14) src.flip(0);
    rd(ST, "ovf", stat(4'hf, 1'b1, 8'hc0));
    chk("irq masked", {31'h0, irq}, 32'h0);
    rd(ETC_IRQ_STATUS_OFS, "irq st", 32'h3);
    bus(1'b1, ETC_IRQ_MASK_OFS, 4'h1, 32'h3);
    repeat (2) @(posedge clock);
    chk("irq on", {31'h0, irq}, 32'h1);
    bus(1'b1, ETC_IRQ_STATUS_OFS, 4'h1, 32'h3);
    repeat (2) @(posedge clock);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    bus(1'b1, ST, 4'h5, 32'h100c1);
    rd(ST, "cleared", stat(4'h0, 1'b0, 8'hc1));
    repeat (16) src.flip(0);
    rd(ST, "chain ovf", stat(4'hf, 1'b0, 8'hc1));
    bus(1'b1, ETC_UNIT_INDEX_OFS, 4'h2, 32'h100);
    src.flip(1);
    rd(ST, "unit1", 32'h0);
    finish_test();
  end
endmodule // etc_event_capture_tb
bind etc_event_capture etc_event_capture_checker #(.UNITS(UNITS)) u_chk (.clock(clock), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .event_in(event_in), .unit_done(unit_done), .irq(irq));
`default_nettype wire
